//--- src/clk_sel_defs.vh
// Constants for start-up reset and system clock selection
`ifndef CLK_SEL_DEFS_VH
`define CLK_SEL_DEFS_VH
`define ADDR_W 4
`define DATA_W 8
`define REG_CTRL 4'h0
`define REG_STAT 4'h1
`define REG_STEP 4'h2
`define CTRL_FAILSAFE 0
`define CTRL_OFFTIME_LO 1
`define CTRL_OFFTIME_HI 4
`define CTRL_RST 8'h00
`define STAT_STANDSTILL 0
`define STAT_EXT 1
`define STAT_FAILED 2
`define STAT_HALTED 3
`define STANDSTILL_LOG2 20
`define OSC_MHZ 14
`define FAIL_MIN_CYC 32
`define FAIL_MAX_CYC 48
`define SEL_INT 4'h1
`define SEL_TO_EXT 4'h2
`define SEL_EXT 4'h4
`define SEL_TO_INT 4'h8
`endif

//--- src/clk_glitch_free_mux.v
// Glitch-free two-input clock switch with break-before-make handover
`timescale 1ns/1ps
`include "clk_sel_defs.vh"
module clk_glitch_free_mux (
   input wire i_clk_int,
   input wire i_clk_ext,
   input wire i_rst,
   input wire i_sel_ext,
   output wire o_clk,
   output wire o_int_on,
   output wire o_ext_on
);
   reg int_a_ff, int_b_ff, ext_a_ff, ext_b_ff;
   wire ext_clr;
   // A dead external clock cannot clock its own disable, so a dropped
   // select clears that side at once; select only drops after loss
   assign ext_clr = i_rst | ~i_sel_ext;
   // Each side enables only after the other has stopped, on its own low phase
   always @(posedge i_clk_int or posedge i_rst) begin
      if (i_rst) begin
         int_a_ff <= 1'b1;
      end else begin
         int_a_ff <= ~i_sel_ext & ~ext_b_ff;
      end
   end
   always @(negedge i_clk_int or posedge i_rst) begin
      if (i_rst) begin
         int_b_ff <= 1'b1;
      end else begin
         int_b_ff <= int_a_ff;
      end
   end
   always @(posedge i_clk_ext or posedge ext_clr) begin
      if (ext_clr) begin
         ext_a_ff <= 1'b0;
      end else begin
         ext_a_ff <= i_sel_ext & ~int_b_ff;
      end
   end
   always @(negedge i_clk_ext or posedge ext_clr) begin
      if (ext_clr) begin
         ext_b_ff <= 1'b0;
      end else begin
         ext_b_ff <= ext_a_ff;
      end
   end
   assign o_clk = (i_clk_int & int_b_ff) | (i_clk_ext & ext_b_ff);
   assign o_int_on = int_b_ff;
   assign o_ext_on = ext_b_ff;
endmodule

//--- src/stepper_clock_select_failsafe.v
// Start-up reset, system clock source selection and clock failsafe
//
// Overview of operation
// - Start-up reset clears registers, ignores accesses
// - Reset released only when both supplies good
// - Clock pin low: run from internal oscillator
// - First high on pin selects external clock
// - Standstill flag after 2^20 clocks without step
// - Failsafe off: lost external clock halts logic
// - Failsafe on: fall back within 32-48 cycles
// - Failsafe bit enables low-side short protection
// - Short-to-ground detection works without clock
// - Undervoltage resets logic, drivers off, registers zero
`timescale 1ns/1ps
`include "clk_sel_defs.vh"
module stepper_clock_select_failsafe #(
   parameter STANDSTILL_CYC = (1 << `STANDSTILL_LOG2),
   parameter OSC_FREQ_MHZ = `OSC_MHZ
) (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_main_supply_ok,
   input wire i_io_supply_ok,
   input wire i_clk_pin,
   input wire i_step,
   input wire i_driver_enable_low,
   input wire i_short_gnd_detect,
   input wire i_short_gnd_enable,
   input wire [`ADDR_W-1:0] i_addr,
   input wire [`DATA_W-1:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [`DATA_W-1:0] o_rdata,
   output reg o_sys_clk_ext,
   output reg o_osc_enable,
   output reg o_standstill_flag,
   output reg o_clock_failsafe_enable,
   output reg o_lowside_prot_enable,
   output reg o_highside_sens_high,
   output reg o_power_stage_on,
   output reg o_short_gnd_trip,
   output reg o_logic_rst
);
   // i_clk is the internal oscillator; it drives the monitor logic
   wire rst_any;
   wire sys_clk;
   wire int_on;
   wire ext_on;
   reg [2:0] pin_sync_ff;
   reg [2:0] step_sync_ff;
   reg [2:0] sup_sync_ff;
   reg step_lvl_ff;
   reg [`DATA_W-1:0] ctrl_ff;
   reg [3:0] sel_ff;
   reg [3:0] nxt_sel;
   reg ext_ok_ff;
   reg failed_ff;
   reg [5:0] quiet_ff;
   reg [20:0] still_ff;
   reg [2:0] stuck_ff;
   reg short_ff;
   wire pin_lvl;
   wire pin_edge;
   wire step_rise;
   wire sup_ok;
   wire sel_ext_req;

   assign rst_any = i_sys_rst | ~(i_main_supply_ok & i_io_supply_ok);

   always @(posedge i_clk or posedge rst_any) begin
      if (rst_any) begin
         pin_sync_ff <= 3'h0;
         step_sync_ff <= 3'h0;
         sup_sync_ff <= 3'h0;
         step_lvl_ff <= 1'b0;
      end else begin
         pin_sync_ff <= {pin_sync_ff[1:0], i_clk_pin};
         step_sync_ff <= {step_sync_ff[1:0], i_step};
         sup_sync_ff <= {sup_sync_ff[1:0], 1'b1};
         // Step level counts only once the last two stages agree
         step_lvl_ff <= step_sync_ff[2] & step_sync_ff[1];
      end
   end
   assign pin_lvl = pin_sync_ff[2] & pin_sync_ff[1];
   assign pin_edge = pin_sync_ff[2] ^ pin_sync_ff[1];
   assign step_rise = step_sync_ff[2] & step_sync_ff[1] & ~step_lvl_ff;
   assign sup_ok = sup_sync_ff[2] & sup_sync_ff[1];

   // Monitor of the external pin: stuck for too long means clock lost
   always @(posedge i_clk or posedge rst_any) begin
      if (rst_any) begin
         quiet_ff <= 6'h00;
         ext_ok_ff <= 1'b0;
      end else if (pin_edge) begin
         quiet_ff <= 6'h00;
         ext_ok_ff <= 1'b1;
      end else if (quiet_ff != `FAIL_MIN_CYC) begin
         quiet_ff <= quiet_ff + 6'h01;
      end else begin
         ext_ok_ff <= 1'b0;
      end
   end

   // Source selection state machine
   always @* begin
      nxt_sel = sel_ff;
      case (sel_ff)
         `SEL_INT: begin
            // First high level latches external clock
            if (pin_lvl && !failed_ff) begin
               nxt_sel = `SEL_TO_EXT;
            end
         end
         `SEL_TO_EXT: begin
            if (ext_on && !int_on) begin
               nxt_sel = `SEL_EXT;
            end
         end
         `SEL_EXT: begin
            if (!ext_ok_ff && ctrl_ff[`CTRL_FAILSAFE]) begin
               nxt_sel = `SEL_TO_INT;
            end
         end
         `SEL_TO_INT: begin
            if (int_on) begin
               nxt_sel = `SEL_INT;
            end
         end
         default: begin
            nxt_sel = `SEL_INT;
         end
      endcase
   end

   always @(posedge i_clk or posedge rst_any) begin
      if (rst_any) begin
         sel_ff <= `SEL_INT;
         failed_ff <= 1'b0;
      end else begin
         sel_ff <= nxt_sel;
         if (sel_ff == `SEL_EXT && nxt_sel == `SEL_TO_INT) begin
            failed_ff <= 1'b1;
         end
      end
   end

   assign sel_ext_req = (sel_ff == `SEL_TO_EXT) || (sel_ff == `SEL_EXT);

   clk_glitch_free_mux u_mux (
      .i_clk_int(i_clk),
      .i_clk_ext(i_clk_pin),
      .i_rst(rst_any),
      .i_sel_ext(sel_ext_req),
      .o_clk(sys_clk),
      .o_int_on(int_on),
      .o_ext_on(ext_on)
   );

   // Standstill counter and register port on the selected system clock
   // Without failsafe this clock simply stops with the pin
   always @(posedge sys_clk or posedge rst_any) begin
      if (rst_any) begin
         // Registers cleared, port held in reset
         ctrl_ff <= `CTRL_RST;
         still_ff <= 21'h000000;
         o_standstill_flag <= 1'b0;
         o_rdata <= {`DATA_W{1'b0}};
      end else begin
         if (step_rise) begin
            still_ff <= 21'h000000;
            o_standstill_flag <= 1'b0;
         end else if (still_ff >= STANDSTILL_CYC[20:0] - 21'h000001) begin
            o_standstill_flag <= 1'b1;
         end else begin
            still_ff <= still_ff + 21'h000001;
         end
         if (sup_ok && i_wr && i_addr == `REG_CTRL) begin
            ctrl_ff <= i_wdata;
         end
         o_rdata <= {`DATA_W{1'b0}};
         if (sup_ok && i_rd) begin
            case (i_addr)
               `REG_CTRL: begin
                  o_rdata <= ctrl_ff;
               end
               `REG_STAT: begin
                  o_rdata <= {4'h0, stuck_ff[0], failed_ff,
                     o_sys_clk_ext, o_standstill_flag};
               end
               default: begin
                  o_rdata <= {`DATA_W{1'b0}};
               end
            endcase
         end
      end
   end

   // Outputs of source state and protection controls
   always @(posedge i_clk or posedge rst_any) begin
      if (rst_any) begin
         o_sys_clk_ext <= 1'b0;
         o_osc_enable <= 1'b1;
         o_clock_failsafe_enable <= 1'b0;
         o_lowside_prot_enable <= 1'b0;
         o_highside_sens_high <= 1'b0;
         o_power_stage_on <= 1'b0;
         o_logic_rst <= 1'b1;
         stuck_ff <= 3'h0;
      end else begin
         o_sys_clk_ext <= ext_on;
         // Oscillator runs until external takes over; with failsafe set it always runs
         o_osc_enable <= int_on | ~ctrl_ff[`CTRL_FAILSAFE] & ~ext_on
            | ctrl_ff[`CTRL_FAILSAFE];
         o_clock_failsafe_enable <= ctrl_ff[`CTRL_FAILSAFE];
         o_lowside_prot_enable <= ctrl_ff[`CTRL_FAILSAFE];
         o_highside_sens_high <= ctrl_ff[`CTRL_FAILSAFE];
         // Zero off-time or enable-low high stops stage
         o_power_stage_on <= ~i_driver_enable_low
            & (|ctrl_ff[`CTRL_OFFTIME_HI:`CTRL_OFFTIME_LO]);
         o_logic_rst <= ~sup_ok;
         stuck_ff <= {stuck_ff[1:0], (sel_ff == `SEL_EXT) & ~ext_ok_ff
            & ~ctrl_ff[`CTRL_FAILSAFE]};
      end
   end

   always @(posedge i_short_gnd_detect or posedge rst_any) begin
      if (rst_any) begin
         short_ff <= 1'b0;
      end else begin
         short_ff <= i_short_gnd_enable;
      end
   end
   always @* begin
      o_short_gnd_trip = short_ff;
   end
endmodule

//--- dv/clk_sel_properties.sv
// Port assertions for clock select and start-up reset
`timescale 1ns/1ps
module clk_sel_checker #(parameter STANDSTILL_CYC = 64) (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_main_supply_ok,
   input wire i_io_supply_ok,
   input wire i_clk_pin,
   input wire i_step,
   input wire o_sys_clk_ext,
   input wire o_osc_enable,
   input wire o_standstill_flag,
   input wire o_clock_failsafe_enable,
   input wire o_lowside_prot_enable,
   input wire o_highside_sens_high,
   input wire o_power_stage_on,
   input wire o_logic_rst
);
   wire rst_any = i_sys_rst | ~i_main_supply_ok | ~i_io_supply_ok;
   reg [7:0] idle_ff;
   reg [31:0] quiet_ff;
   reg pin_ff;
   // Cycles since last pin edge, and since last step
   always @(posedge i_clk or posedge rst_any) begin
      if (rst_any) begin
         idle_ff <= 8'h00;
         quiet_ff <= 32'h0;
         pin_ff <= 1'b0;
      end else begin
         pin_ff <= i_clk_pin;
         if (pin_ff != i_clk_pin) idle_ff <= 8'h00;
         else if (idle_ff != 8'hff) idle_ff <= idle_ff + 8'h01;
         if (i_step) quiet_ff <= 32'h1;
         else if (o_sys_clk_ext) quiet_ff <= 32'h0;
         else if (quiet_ff != 32'h0) quiet_ff <= quiet_ff + 32'h1;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (rst_any);
   sequence ext_up;
      $rose(o_sys_clk_ext) && !o_clock_failsafe_enable;
   endsequence
   sequence osc_off;
      ##[0:4] !o_osc_enable;
   endsequence
   chk_rst_clears:
   assert property (o_logic_rst |-> !o_power_stage_on
      && !o_clock_failsafe_enable) else $error("regs not clear");
   chk_supply_rst:
   assert property (@(posedge i_clk) disable iff (i_sys_rst)
      !(i_main_supply_ok && i_io_supply_ok) |-> o_logic_rst)
      else $error("supply low, no reset");
   chk_int_osc_on:
   assert property (!o_sys_clk_ext |-> o_osc_enable)
      else $error("internal source without osc");
   chk_ext_osc_off:
   assert property (ext_up |-> osc_off) else $error("osc left on");
   chk_standstill_time:
   assert property (quiet_ff == STANDSTILL_CYC - 8 |->
      !o_standstill_flag ##16 o_standstill_flag)
      else $error("standstill timing");
   chk_halt_stays:
   assert property (!o_clock_failsafe_enable && !o_osc_enable
      |=> !o_osc_enable) else $error("osc back without failsafe");
   chk_fallback_time:
   assert property (o_clock_failsafe_enable && idle_ff == 8'd52
      |-> !o_sys_clk_ext) else $error("no fallback");
   chk_prot_follow:
   assert property (o_lowside_prot_enable == o_clock_failsafe_enable
      && o_highside_sens_high == o_clock_failsafe_enable)
      else $error("protection bits differ");
endmodule
bind stepper_clock_select_failsafe clk_sel_checker #(
   .STANDSTILL_CYC(STANDSTILL_CYC)) u_chk (.i_clk, .i_sys_rst,
   .i_main_supply_ok, .i_io_supply_ok, .i_clk_pin, .i_step,
   .o_sys_clk_ext, .o_osc_enable, .o_standstill_flag,
   .o_clock_failsafe_enable, .o_lowside_prot_enable,
   .o_highside_sens_high, .o_power_stage_on, .o_logic_rst);

//--- dv/ext_clk_source.sv
// External clock source model with pull-down on the pin
`timescale 1ns/1ps
module ext_clk_source #(parameter HALF_NS = 42) (
   input wire i_run,
   output reg o_clk_pin
);
   initial o_clk_pin = 1'b0;
   always begin
      #HALF_NS;
      o_clk_pin = i_run ? ~o_clk_pin : 1'b0;
   end
endmodule

//--- dv/stepper_clock_select_failsafe_tb.sv
// Self-checking bench for clock select and start-up reset
`timescale 1ns/1ps
module stepper_clock_select_failsafe_tb;
   reg i_clk, i_sys_rst, i_main_supply_ok, i_io_supply_ok, i_step;
   reg i_driver_enable_low, i_short_gnd_detect, i_short_gnd_enable;
   reg i_wr, i_rd, run;
   reg [3:0] i_addr;
   reg [7:0] i_wdata, d;
   wire [7:0] o_rdata;
   wire i_clk_pin, o_sys_clk_ext, o_osc_enable, o_standstill_flag;
   wire o_clock_failsafe_enable, o_lowside_prot_enable;
   wire o_highside_sens_high, o_power_stage_on, o_short_gnd_trip;
   wire o_logic_rst;
   integer failures, total_checks, cycles;
   stepper_clock_select_failsafe #(.STANDSTILL_CYC(64)) uut (.i_clk,
      .i_sys_rst, .i_main_supply_ok, .i_io_supply_ok, .i_clk_pin,
      .i_step, .i_driver_enable_low, .i_short_gnd_detect,
      .i_short_gnd_enable, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .o_sys_clk_ext, .o_osc_enable, .o_standstill_flag,
      .o_clock_failsafe_enable, .o_lowside_prot_enable,
      .o_highside_sens_high, .o_power_stage_on, .o_short_gnd_trip,
      .o_logic_rst);
   ext_clk_source src (.i_run(run), .o_clk_pin(i_clk_pin));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   task wrap_up;
      begin
         $display("checks %0d failures %0d", total_checks, failures);
         if (failures == 0 && total_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   always @(posedge i_clk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         failures = failures + 1;
         wrap_up;
      end
   end
   task chk(input string nm, input [7:0] e, input [7:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task c1(input string nm, input e, input g);
      chk(nm, {7'h0, e}, {7'h0, g});
   endtask
   task tick(input integer n);
      repeat (n) @(posedge i_clk);
   endtask
   task wr(input [3:0] a, input [7:0] v);
      begin
         tick(1);
         i_wr <= 1'b1;
         i_addr <= a;
         i_wdata <= v;
         tick(1);
         i_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a);
      begin
         tick(1);
         i_rd <= 1'b1;
         i_addr <= a;
         tick(1);
         i_rd <= 1'b0;
         #1 d = o_rdata;
      end
   endtask
   task wait_ext;
      repeat (60) if (o_sys_clk_ext !== 1'b1) tick(1);
   endtask
   task t_reset;
      begin
         c1("in_reset", 1'b1, o_logic_rst);
         wr(4'h0, 8'h01);
         tick(4);
         rd(4'h0);
         chk("ignored", 8'h00, d);
         wr(4'h0, 8'h01);
         tick(1);
         i_io_supply_ok <= 1'b0;
         tick(1);
         c1("io_rst", 1'b1, o_logic_rst);
         c1("fs_clr", 1'b0, o_clock_failsafe_enable);
         i_io_supply_ok <= 1'b1;
         tick(5);
         c1("run", 1'b0, o_logic_rst);
         $display("reset test done");
      end
   endtask
   task t_regs;
      begin
         wr(4'h0, 8'h03);
         wr(4'h2, 8'hff);
         rd(4'h0);
         chk("ctrl", 8'h03, d);
         rd(4'h2);
         chk("reserved", 8'h00, d);
         c1("lowside", 1'b1, o_lowside_prot_enable);
         c1("hs_sens", 1'b1, o_highside_sens_high);
         c1("pwr_on", 1'b1, o_power_stage_on);
         $display("register test done");
      end
   endtask
   task t_still;
      begin
         tick(1);
         i_step <= 1'b1;
         tick(2);
         i_step <= 1'b0;
         tick(60);
         c1("still_lo", 1'b0, o_standstill_flag);
         tick(8);
         c1("still_hi", 1'b1, o_standstill_flag);
         $display("standstill test done");
      end
   endtask
   task t_failsafe;
      begin
         c1("int_src", 1'b0, o_sys_clk_ext);
         run <= 1'b1;
         wait_ext;
         c1("ext_on", 1'b1, o_sys_clk_ext);
         i_driver_enable_low <= 1'b1;
         tick(8);
         run <= 1'b0;
         tick(28);
         c1("not_yet", 1'b1, o_sys_clk_ext);
         tick(20);
         c1("fallback", 1'b0, o_sys_clk_ext);
         c1("osc_back", 1'b1, o_osc_enable);
         c1("pwr_off", 1'b0, o_power_stage_on);
         rd(4'h1);
         chk("failed", 8'h04, d & 8'h04);
         $display("failsafe test done");
      end
   endtask
   task t_halt;
      begin
         tick(1);
         i_sys_rst <= 1'b1;
         tick(1);
         i_sys_rst <= 1'b0;
         tick(4);
         run <= 1'b1;
         wait_ext;
         tick(8);
         c1("osc_off", 1'b0, o_osc_enable);
         run <= 1'b0;
         i_short_gnd_enable <= 1'b1;
         tick(80);
         c1("halted", 1'b1, o_sys_clk_ext);
         c1("osc_stays", 1'b0, o_osc_enable);
         i_short_gnd_detect <= 1'b1;
         tick(1);
         i_short_gnd_detect <= 1'b0;
         tick(1);
         c1("short", 1'b1, o_short_gnd_trip);
         rd(4'h1);
         chk("halt_rd", 8'h00, d);
         $display("halt test done");
      end
   endtask
   initial begin
      failures = 0;
      total_checks = 0;
      cycles = 0;
      i_sys_rst = 1'b1;
      i_main_supply_ok = 1'b1;
      i_io_supply_ok = 1'b1;
      i_step = 1'b0;
      i_driver_enable_low = 1'b0;
      i_short_gnd_detect = 1'b0;
      i_short_gnd_enable = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      run = 1'b0;
      i_addr = 4'h0;
      i_wdata = 8'h00;
      tick(2);
      i_sys_rst <= 1'b0;
      t_reset;
      t_regs;
      t_still;
      t_failsafe;
      t_halt;
      wrap_up;
   end
endmodule
